// ---- lwdt_top.sv ----
// loop watchdog / interval timer with apb register access
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
// What this block does
// - mode select bit set makes the timer a loop watchdog
// - clock code picks overflow period 2^11..2^17, code 7 gives 2^19
// - main clock is oscillator clock, or half of it when mode bit clear
// - writing run bit one starts watchdog counting
// - every run write of one clears counter and restarts period
// - watchdog overflow gives reset or nmi, chosen by action bit
// - counting continues in halt, freezes in stop
// - first period after restart may be up to 0.5% short
// - counting halts while cpu runs on subsystem clock
// - mode select zero: interval timer, repeated maskable requests
// - interval mode starts on run bit, same periods
// - interval request obeys its mask and priority flags
// - interval request has highest default maskable priority
// - once watchdog mode set, interval mode gone until reset
// - mode select and action bits cannot be cleared by software
// - run bit cannot be cleared by software
// - setting mode select while interval flag pends raises nmi
module lwdt_top (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // cpu state
  input  wire lwdt_pkg::lwdt_cpu_state_type cpu_state,
  // requests out
  output lwdt_pkg::lwdt_req_type       req
);
  import lwdt_pkg::*;

  logic                  run;
  logic                  wd_mode_sel;
  logic                  overflow_action_sel;
  logic [7:0]            clk_select_reg2;
  logic                  osc_mode_bit;
  logic                  interval_int_mask;
  logic                  interval_int_priority;
  logic                  interval_int_flag;
  logic [lwdt_cnt_w-1:0] count;
  logic                  count_tick;
  logic                  count_en;
  logic                  overflow;
  logic                  restart;
  logic                  setup;
  logic                  wr_en;
  logic                  hit_mode;
  logic                  hit_clk;
  logic                  hit_ctl;
  logic                  mapped;
  logic                  nmi_req;
  logic                  wd_reset_req;
  logic [7:0]            wd_mode_reg;
  lwdt_action_type       action;

  // apb decode: zero wait, errors only for unmapped addresses
  assign hit_mode = (paddr == lwdt_mode_addr);
  assign hit_clk  = (paddr == lwdt_clk_sel_addr);
  assign hit_ctl  = (paddr == lwdt_irq_ctl_addr);
  assign mapped   = hit_mode | hit_clk | hit_ctl;
  assign setup    = psel && !penable;
  assign wr_en    = psel && penable && pwrite && mapped;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  assign wd_mode_reg = {run, 2'b00, wd_mode_sel, overflow_action_sel, 3'b000};

  // read data captured in setup, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (setup && !pwrite) begin
      unique case (1'b1)
        hit_mode: prdata <= {24'h000000, wd_mode_reg};
        hit_clk:  prdata <= {24'h000000, clk_select_reg2};
        hit_ctl:  prdata <= {28'h0000000, interval_int_flag, interval_int_priority,
                             interval_int_mask, osc_mode_bit};
        default:  prdata <= '0;
      endcase
    end
  end

  // every write of one to run restarts the period
  assign restart = wr_en && hit_mode && pwdata[lwdt_run_pos];

  // mode bits only ever set by software; reset alone clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run                 <= lwdt_mode_rst[lwdt_run_pos];
      wd_mode_sel         <= lwdt_mode_rst[lwdt_wd_sel_pos];
      overflow_action_sel <= lwdt_mode_rst[lwdt_ovf_act_pos];
    end else if (wr_en && hit_mode) begin
      run                 <= run | pwdata[lwdt_run_pos];
      wd_mode_sel         <= wd_mode_sel | pwdata[lwdt_wd_sel_pos];
      overflow_action_sel <= overflow_action_sel | pwdata[lwdt_ovf_act_pos];
    end
  end

  // clock select: software should stop the timer before rewriting it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_select_reg2 <= lwdt_clk_sel_rst;
    end else if (wr_en && hit_clk) begin
      clk_select_reg2 <= pwdata[7:0] & lwdt_clk_sel_mask;
    end
  end

  // oscillator mode, mask and priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_mode_bit          <= lwdt_irq_ctl_rst[lwdt_osc_mode_pos];
      interval_int_mask     <= lwdt_irq_ctl_rst[lwdt_mask_pos];
      interval_int_priority <= lwdt_irq_ctl_rst[lwdt_prio_pos];
    end else if (wr_en && hit_ctl) begin
      osc_mode_bit          <= pwdata[lwdt_osc_mode_pos];
      interval_int_mask     <= pwdata[lwdt_mask_pos];
      interval_int_priority <= pwdata[lwdt_prio_pos];
    end
  end

  // no counting in stop or on subsystem clock; halt keeps counting
  assign count_en = run && !cpu_state.stop_mode && !cpu_state.on_subclk;

  lwdt_prescaler u_prescaler (
    .pclk         (pclk),
    .presetn      (presetn),
    .count_en     (count_en),
    .osc_mode_bit (osc_mode_bit),
    .clock_code   (clk_select_reg2[2:0]),
    .count_tick   (count_tick)
  );

  assign overflow = count_tick && (count == lwdt_cnt_max) && !restart;

  // main counter; restart beats a tick in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;
    end else if (count_tick) begin
      count <= count + 1'b1;
    end
  end

  // overflow action decode
  always_comb begin
    if (!wd_mode_sel) begin
      action = lwdt_act_interval;
    end else if (overflow_action_sel) begin
      action = lwdt_act_reset;
    end else begin
      action = lwdt_act_nmi;
    end
  end

  // interval flag: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_int_flag <= 1'b0;
    end else if (overflow && action == lwdt_act_interval) begin
      interval_int_flag <= 1'b1;
    end else if (wr_en && hit_ctl && !pwdata[lwdt_flag_pos]) begin
      interval_int_flag <= 1'b0;
    end
  end

  // one-cycle nmi and reset requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_req      <= 1'b0;
      wd_reset_req <= 1'b0;
    end else begin
      // entering watchdog mode with a pending interval flag gives nmi
      nmi_req      <= (overflow && action == lwdt_act_nmi)
                   || (wr_en && hit_mode && pwdata[lwdt_wd_sel_pos] && !wd_mode_sel
                       && interval_int_flag);
      wd_reset_req <= overflow && action == lwdt_act_reset;
    end
  end

  // interval request gated by mask; priority passed beside it
  assign req.interval_irq           = interval_int_flag && !interval_int_mask
                                      && !wd_mode_sel;
  assign req.interval_irq_high_prio = !interval_int_priority;
  assign req.nmi_req                = nmi_req;
  assign req.wd_reset_req           = wd_reset_req;
endmodule

// ---- lwdt_prescaler.sv ----
// package of constants and types, plus the count-clock prescaler
package lwdt_pkg;
  // register indexes as printed; byte address is four times the index
  localparam logic [15:0] lwdt_mode_idx     = 16'hfff9;
  localparam logic [15:0] lwdt_clk_sel_idx  = 16'hff42;
  localparam logic [15:0] lwdt_irq_ctl_idx  = 16'h0010;
  localparam logic [31:0] lwdt_mode_addr    = {14'h0000, lwdt_mode_idx, 2'b00};
  localparam logic [31:0] lwdt_clk_sel_addr = {14'h0000, lwdt_clk_sel_idx, 2'b00};
  localparam logic [31:0] lwdt_irq_ctl_addr = {14'h0000, lwdt_irq_ctl_idx, 2'b00};
  // mode register fields
  localparam int          lwdt_run_pos      = 7;
  localparam int          lwdt_wd_sel_pos   = 4;
  localparam int          lwdt_ovf_act_pos  = 3;
  localparam logic [7:0]  lwdt_mode_rst     = 8'h00;
  // clock select register: bit 3 reads zero, code in bits 2..0
  localparam logic [7:0]  lwdt_clk_sel_mask = 8'hf7;
  localparam logic [7:0]  lwdt_clk_sel_rst  = 8'h00;
  // own control register fields
  localparam int          lwdt_osc_mode_pos = 0;
  localparam int          lwdt_mask_pos     = 1;
  localparam int          lwdt_prio_pos     = 2;
  localparam int          lwdt_flag_pos     = 3;
  localparam logic [3:0]  lwdt_irq_ctl_rst  = 4'h2;
  // main counter is 8 bits: overflow after 2^8 count-clock ticks
  localparam int          lwdt_cnt_w        = 8;
  localparam int          lwdt_div_w        = 11;
  localparam logic [7:0]  lwdt_cnt_max      = 8'hff;

  typedef enum logic [1:0] {
    lwdt_act_interval = 2'b00,
    lwdt_act_nmi      = 2'b01,
    lwdt_act_reset    = 2'b10
  } lwdt_action_type;

  // cpu power and clock state
  typedef struct packed {
    logic stop_mode;
    logic on_subclk;
  } lwdt_cpu_state_type;

  // requests towards interrupt controller and reset logic
  typedef struct packed {
    logic interval_irq;
    logic interval_irq_high_prio;
    logic nmi_req;
    logic wd_reset_req;
  } lwdt_req_type;
endpackage

`timescale 1ns/10ps
module lwdt_prescaler (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       count_en,
  input  wire logic       osc_mode_bit,
  input  wire logic [2:0] clock_code,
  // count clock pulse
  output logic            count_tick
);
  import lwdt_pkg::*;

  logic                  half;
  logic [lwdt_div_w-1:0] div;
  logic                  fxx_tick;
  logic [lwdt_div_w-1:0] sel_mask;

  // fx directly or fx/2 as the main system clock
  assign fxx_tick = osc_mode_bit | half;

  // half-rate phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half <= 1'b0;
    end else if (count_en) begin
      half <= ~half;
    end
  end

  // divider is never cleared on restart, so first period may run short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= '0;
    end else if (count_en && fxx_tick) begin
      div <= div + 1'b1;
    end
  end

  // codes 0..6 divide by 2^3..2^9, code 7 by 2^11
  always_comb begin
    unique case (clock_code)
      3'h7:    sel_mask = 11'h7ff;
      default: sel_mask = 11'((12'h008 << clock_code) - 12'h001);
    endcase
  end

  assign count_tick = count_en && fxx_tick && ((div & sel_mask) == sel_mask);
endmodule

// ---- lwdt_monitor.sv ----
// port checker for the watchdog timer
`timescale 1ns/10ps
module lwdt_monitor (
  // clock, reset and bus
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  // cpu side
  input wire lwdt_pkg::lwdt_cpu_state_type cpu_state,
  input wire lwdt_pkg::lwdt_req_type       req
);
  import lwdt_pkg::*;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       acc;
  logic       mapped;
  logic       wd_seen;
  logic [2:0] frz;
  assign acc = psel && penable;
  assign mapped = paddr inside {lwdt_mode_addr, lwdt_clk_sel_addr, lwdt_irq_ctl_addr};
  // watchdog mode once written stays until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_seen <= 1'b0;
    else if (acc && pwrite && paddr == lwdt_mode_addr && pwdata[lwdt_wd_sel_pos]) begin
      wd_seen <= 1'b1;
    end
  end
  // frozen cycles, saturating so long stops stay covered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) frz <= 3'h0;
    else if (!(cpu_state.stop_mode || cpu_state.on_subclk)) frz <= 3'h0;
    else if (frz != 3'h7) frz <= frz + 3'h1;
  end
  zero_wait_a: assert property (acc |-> pready) else $error("pready low in access");
  refuse_map_a: assert property (acc |-> pslverr == !mapped) else $error("pslverr wrong");
  upper_zero_a: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read upper bits set");
  nmi_pulse_a: assert property (req.nmi_req |=> !req.nmi_req)
    else $error("nmi longer than one cycle");
  rst_pulse_a: assert property (req.wd_reset_req |=> !req.wd_reset_req)
    else $error("reset request too long");
  one_action_a: assert property (!(req.nmi_req && req.wd_reset_req))
    else $error("both overflow actions");
  restart_quiet_a: assert property (
    wd_seen && acc && pwrite && paddr == lwdt_mode_addr && pwdata[lwdt_run_pos]
    |=> (!req.nmi_req && !req.wd_reset_req)[*8]) else $error("action after restart");
  interval_gone_a: assert property (wd_seen |-> !req.interval_irq)
    else $error("interval request in watchdog mode");
  frozen_quiet_a: assert property (
    frz == 3'h7 |-> !req.nmi_req && !req.wd_reset_req) else $error("action while frozen");
endmodule

// ---- lwdt_cpu_model.sv ----
// interrupt controller and reset logic model: counts requests
`timescale 1ns/10ps
module lwdt_cpu_model (
  // clock and requests in
  input wire logic                   pclk,
  input wire lwdt_pkg::lwdt_req_type req,
  // counts seen
  output int                         nmi_cnt,
  output int                         rst_cnt
);
  import lwdt_pkg::*;

  // counts survive system reset so the bench sees earlier requests
  always_ff @(posedge pclk) begin
    if (req.nmi_req) nmi_cnt <= nmi_cnt + 1;
    if (req.wd_reset_req) rst_cnt <= rst_cnt + 1;
  end
endmodule

// ---- loop_watchdog_interval_timer_bench.sv ----
// self-checking bench for the watchdog and interval timer
`timescale 1ns/10ps
module loop_watchdog_interval_timer_bench;
  import lwdt_pkg::*;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [31:0]        paddr = 32'h0;
  logic [31:0]        pwdata = 32'h0;
  logic               pready, pslverr, err;
  logic [31:0]        prdata, rd;
  lwdt_cpu_state_type cpu_state = '0;
  lwdt_req_type       req;
  int                 n_mismatch, comparisons, cyc, nmi_cnt, rst_cnt, n;
  always #10 pclk = ~pclk;
  lwdt_top lwdt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cpu_state(cpu_state), .req(req));
  lwdt_cpu_model lwdt_cpu_model_i (.pclk(pclk), .req(req), .nmi_cnt(nmi_cnt),
    .rst_cnt(rst_cnt));
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int lo, input int hi);
    check({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask
  // cycles until request bit k rises; capped so a dead timer fails
  task automatic wait_req(input int k);
    n = 0;
    do begin
      @(posedge pclk);
      #1;
      n++;
    end while (req[k] !== 1'b1 && n < 5000);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // run ceiling well above the expected 22k cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lwdt_mode_addr, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, lwdt_irq_ctl_addr, 32'h0);
    check(rd, 32'h2);
    check(req, 32'h4);
    apb(1'b1, 32'h4, 32'hff);
    check(err, 1'b1);
    apb(1'b1, lwdt_clk_sel_addr, 32'hf8);
    apb(1'b0, lwdt_clk_sel_addr, 32'h0);
    check(rd, 32'hf0);
    // interval mode at full oscillator rate
    apb(1'b1, lwdt_irq_ctl_addr, 32'h1);
    apb(1'b1, lwdt_mode_addr, 32'h80);
    wait_req(3);
    rng(2040, 2050);
    apb(1'b1, lwdt_mode_addr, 32'h0);
    apb(1'b0, lwdt_mode_addr, 32'h0);
    check(rd, 32'h80);
    // flag kept pending so mask and priority alone decide the request
    apb(1'b1, lwdt_irq_ctl_addr, 32'hf);
    check(req, 32'h0);
    apb(1'b1, lwdt_irq_ctl_addr, 32'h9);
    check(req, 32'hc);
    apb(1'b1, lwdt_irq_ctl_addr, 32'h1);
    wait_req(3);
    rng(2025, 2050);
    // watchdog with nmi, flag cleared first
    apb(1'b1, lwdt_irq_ctl_addr, 32'h1);
    apb(1'b1, lwdt_mode_addr, 32'h90);
    wait_req(1);
    rng(2040, 2050);
    repeat (3) begin
      repeat (1500) @(posedge pclk);
      apb(1'b1, lwdt_mode_addr, 32'h90);
    end
    check(nmi_cnt, 32'h1);
    // half rate, frozen in stop and on the subsystem clock
    apb(1'b1, lwdt_irq_ctl_addr, 32'h0);
    apb(1'b1, lwdt_mode_addr, 32'h90);
    @(posedge pclk);
    cpu_state <= 2'b10;
    repeat (1500) @(posedge pclk);
    cpu_state <= 2'b01;
    repeat (1500) @(posedge pclk);
    cpu_state <= 2'b00;
    wait_req(1);
    rng(4070, 4100);
    // reset mid-run, then pending flag and reset action
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lwdt_mode_addr, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, lwdt_clk_sel_addr, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, lwdt_irq_ctl_addr, 32'h1);
    apb(1'b1, lwdt_mode_addr, 32'h80);
    wait_req(3);
    n = nmi_cnt;
    apb(1'b1, lwdt_mode_addr, 32'h10);
    repeat (3) @(posedge pclk);
    check(nmi_cnt, n + 1);
    apb(1'b1, lwdt_mode_addr, 32'h88);
    apb(1'b1, lwdt_mode_addr, 32'h0);
    apb(1'b0, lwdt_mode_addr, 32'h0);
    check(rd, 32'h98);
    wait_req(0);
    rng(2030, 2050);
    // model counts one edge after the pulse
    repeat (2) @(posedge pclk);
    check(rst_cnt, 32'h1);
    check(nmi_cnt, 32'h3);
    final_report();
  end
endmodule
bind lwdt_top lwdt_monitor lwdt_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .cpu_state(cpu_state), .req(req));
